// file: lpmc_low_power_mode_control.sv
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module lpmc_low_power_mode_control #(
  parameter logic [7:0] PERIPH_PRESENT = 8'hd7
) (
  input  wire logic                      CLK_SYS_IN,
  input  wire logic                      RST_IN,
  input  wire lpmc_pkg::lpmc_axi_req_type AXI_REQ_IN,
  output var  lpmc_pkg::lpmc_axi_rsp_type AXI_RSP_OUT,
  input  wire logic                      HALT_EXEC_IN,
  input  wire logic                      STOP_EXEC_IN,
  input  wire logic                      STOP_RECOVERY_IN,
  input  wire logic                      IRQ_IN,
  input  wire logic                      WDT_TIMEOUT_IN,
  input  wire logic                      WDT_ENABLE_IN,
  input  wire logic                      EXT_RESET_N_IN,
  input  wire logic                      ADC_TRIGGER_IN,
  input  wire logic                      ADC_DONE_IN,
  input  wire logic                      REF_BUF_SELECTED_IN,
  output var  lpmc_pkg::lpmc_power_type   POWER_OUT
);

  typedef struct packed {
    lpmc_pkg::lpmc_mode_type          mode;
    lpmc_pkg::lpmc_conv_type          conv;
    logic [lpmc_pkg::WAKE_W-1:0]      wake_cnt;
    logic [7:0]                       analog;
    logic [7:0]                       policy;
    logic                             ext_s1;
    logic                             ext_s2;
    logic                             aw_got;
    logic [lpmc_pkg::IDX_W-1:0]       aw_idx;
    logic                             w_got;
    logic [7:0]                       wbyte;
    logic                             wlane;
    lpmc_pkg::lpmc_axi_rsp_type       rsp;
    lpmc_pkg::lpmc_power_type         pwr;
  } lpmc_state_type;

  lpmc_state_type state_reg;
  lpmc_state_type state_next;

  // word index of a byte address
  function automatic logic [lpmc_pkg::IDX_W-1:0] word_index(input logic [lpmc_pkg::ADDR_W-1:0] addr);
    word_index = addr[lpmc_pkg::ADDR_W-1:2];
  endfunction

  // decode of a mapped index
  function automatic logic is_mapped(input logic [lpmc_pkg::IDX_W-1:0] idx);
    is_mapped = (idx == lpmc_pkg::IDX_ANALOG) || (idx == lpmc_pkg::IDX_POLICY) || (idx == lpmc_pkg::IDX_STATUS);
  endfunction

  logic ext_reset_event;
  logic halt_exit_event;
  logic stop_now;
  logic cont_policy;
  logic [1:0] policy_code;
  logic [7:0] analog_eff;

  // halt exit sources; the synchronised pin is only read after its second stage
  assign ext_reset_event = !state_reg.ext_s2;
  assign halt_exit_event = IRQ_IN || WDT_TIMEOUT_IN || ext_reset_event;
  assign stop_now        = (state_reg.mode == lpmc_pkg::MODE_STOP);
  assign policy_code     = state_reg.policy[lpmc_pkg::POLICY_LO +: 2];
  assign cont_policy     = (policy_code == lpmc_pkg::ADC_CONT) || (policy_code == lpmc_pkg::ADC_CONT_ALT);
  assign analog_eff      = state_reg.analog & PERIPH_PRESENT;

  // next state of everything
  always_comb begin
    state_next = state_reg;
    state_next.ext_s1 = EXT_RESET_N_IN;
    state_next.ext_s2 = state_reg.ext_s1;
    state_next.pwr.resume = 1'b0;
    state_next.pwr.reset_exit = 1'b0;
    state_next.pwr.conv_start = 1'b0;

    // power mode sequencing
    unique case (state_reg.mode)
      lpmc_pkg::MODE_ACTIVE: begin
        if (STOP_EXEC_IN) begin
          state_next.mode = lpmc_pkg::MODE_STOP;
        end else if (HALT_EXEC_IN) begin
          state_next.mode = lpmc_pkg::MODE_HALT;
        end
      end
      lpmc_pkg::MODE_HALT: begin
        if (halt_exit_event) begin
          state_next.mode = lpmc_pkg::MODE_ACTIVE;
          state_next.pwr.resume = 1'b1;
          state_next.pwr.reset_exit = ext_reset_event;
        end
      end
      lpmc_pkg::MODE_STOP: begin
        // a plain interrupt or pin reset does not end stop
        if (STOP_RECOVERY_IN) begin
          state_next.mode = lpmc_pkg::MODE_ACTIVE;
          state_next.pwr.resume = 1'b1;
        end
      end
    endcase

    // converter wake sequencing; stop mode ignores a new trigger
    unique case (state_reg.conv)
      lpmc_pkg::CONV_IDLE: begin
        state_next.wake_cnt = lpmc_pkg::WAKE_ZERO;
        if (ADC_TRIGGER_IN && !stop_now) begin
          if (cont_policy) begin
            state_next.conv = lpmc_pkg::CONV_BUSY;
            state_next.pwr.conv_start = 1'b1;
          end else begin
            state_next.conv = lpmc_pkg::CONV_WAKE;
          end
        end
      end
      lpmc_pkg::CONV_WAKE: begin
        if (state_reg.wake_cnt == lpmc_pkg::WAKE_LAST) begin
          state_next.conv = lpmc_pkg::CONV_BUSY;
          state_next.pwr.conv_start = 1'b1;
        end else begin
          state_next.wake_cnt = state_reg.wake_cnt + 8'h01;
        end
      end
      lpmc_pkg::CONV_BUSY: begin
        if (ADC_DONE_IN) begin
          state_next.conv = lpmc_pkg::CONV_IDLE;
        end
      end
    endcase

    // clock and enable outputs, one cycle behind the mode; wdt_run one cycle behind WDT_ENABLE_IN
    state_next.pwr.cpu_run    = (state_reg.mode == lpmc_pkg::MODE_ACTIVE);
    state_next.pwr.pc_hold    = (state_reg.mode != lpmc_pkg::MODE_ACTIVE);
    state_next.pwr.sys_clk_en = !stop_now;
    state_next.pwr.osc_run    = !stop_now;
    state_next.pwr.wdt_run    = WDT_ENABLE_IN;
    state_next.pwr.periph_run = !stop_now;
    // amplifiers and comparators survive stop only with fast recovery set
    state_next.pwr.frec = analog_eff[lpmc_pkg::BIT_FREC];
    state_next.pwr.amp0 = analog_eff[lpmc_pkg::BIT_AMP0] && (!stop_now || analog_eff[lpmc_pkg::BIT_FREC]);
    state_next.pwr.amp1 = analog_eff[lpmc_pkg::BIT_AMP1] && (!stop_now || analog_eff[lpmc_pkg::BIT_FREC]);
    state_next.pwr.cmp0 = analog_eff[lpmc_pkg::BIT_CMP0] && (!stop_now || analog_eff[lpmc_pkg::BIT_FREC]);
    state_next.pwr.cmp1 = analog_eff[lpmc_pkg::BIT_CMP1] && (!stop_now || analog_eff[lpmc_pkg::BIT_FREC]);
    state_next.pwr.low_voltage_detect_enable  = analog_eff[lpmc_pkg::BIT_LVD];
    // converter power: on demand, or continuous outside stop
    state_next.pwr.adc_pwr = (cont_policy && !stop_now) || (state_reg.conv != lpmc_pkg::CONV_IDLE);
    state_next.pwr.ref_pwr = ((cont_policy || (policy_code == lpmc_pkg::ADC_REF_HOLD)) && REF_BUF_SELECTED_IN &&
                              !stop_now) || (state_reg.conv != lpmc_pkg::CONV_IDLE && REF_BUF_SELECTED_IN);

    // write address and data taken in either order
    if (AXI_REQ_IN.awvalid && state_reg.rsp.awready) begin
      state_next.aw_got = 1'b1;
      state_next.aw_idx = word_index(AXI_REQ_IN.awaddr);
    end
    if (AXI_REQ_IN.wvalid && state_reg.rsp.wready) begin
      state_next.w_got = 1'b1;
      state_next.wbyte = AXI_REQ_IN.wdata[7:0];
      state_next.wlane = AXI_REQ_IN.wstrb[0];
    end
    // commit once both halves are held; reserved bits are dropped
    if (state_reg.aw_got && state_reg.w_got && !state_reg.rsp.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.rsp.bvalid = 1'b1;
      state_next.rsp.bresp = is_mapped(state_reg.aw_idx) ? lpmc_pkg::RESP_OKAY : lpmc_pkg::RESP_SLVERR;
      if (state_reg.wlane && state_reg.aw_idx == lpmc_pkg::IDX_ANALOG) begin
        state_next.analog = state_reg.wbyte & lpmc_pkg::ANALOG_MASK;
      end
      if (state_reg.wlane && state_reg.aw_idx == lpmc_pkg::IDX_POLICY) begin
        state_next.policy = state_reg.wbyte & lpmc_pkg::POLICY_MASK;
      end
    end else if (state_reg.rsp.bvalid && AXI_REQ_IN.bready) begin
      state_next.rsp.bvalid = 1'b0;
    end
    state_next.rsp.awready = !state_next.aw_got && !state_next.rsp.bvalid;
    state_next.rsp.wready  = !state_next.w_got && !state_next.rsp.bvalid;

    // reads answer one cycle after the address is taken
    if (AXI_REQ_IN.arvalid && state_reg.rsp.arready) begin
      state_next.rsp.rvalid = 1'b1;
      state_next.rsp.rresp = lpmc_pkg::RESP_OKAY;
      unique case (word_index(AXI_REQ_IN.araddr))
        lpmc_pkg::IDX_ANALOG: state_next.rsp.rdata = {24'h000000, state_reg.analog};
        lpmc_pkg::IDX_POLICY: state_next.rsp.rdata = {24'h000000, state_reg.policy};
        lpmc_pkg::IDX_STATUS: state_next.rsp.rdata = {26'h0000000, state_reg.conv, state_reg.mode};
        default: begin
          state_next.rsp.rdata = 32'h00000000;
          state_next.rsp.rresp = lpmc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (state_reg.rsp.rvalid && AXI_REQ_IN.rready) begin
      state_next.rsp.rvalid = 1'b0;
    end
    state_next.rsp.arready = !state_next.rsp.rvalid;
  end

  // only the power-on/brown-out reset clears the power registers
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= '0;
      state_reg.mode <= lpmc_pkg::MODE_ACTIVE;
      state_reg.conv <= lpmc_pkg::CONV_IDLE;
      state_reg.analog <= lpmc_pkg::ANALOG_RESET;
      state_reg.policy <= lpmc_pkg::POLICY_RESET;
      state_reg.ext_s1 <= 1'b1;
      state_reg.ext_s2 <= 1'b1;
      state_reg.rsp.awready <= 1'b1;
      state_reg.rsp.wready <= 1'b1;
      state_reg.rsp.arready <= 1'b1;
      state_reg.pwr.cpu_run <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flops
  assign AXI_RSP_OUT = state_reg.rsp;
  assign POWER_OUT   = state_reg.pwr;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  sequence s_demand_trigger;
    state_reg.conv == lpmc_pkg::CONV_IDLE && ADC_TRIGGER_IN && !stop_now && !cont_policy;
  endsequence

  sequence s_wake_then_start;
    ##1 (!POWER_OUT.conv_start)[*8] ##118 POWER_OUT.conv_start;
  endsequence

  a_halt_entry_stall: assert property (
    state_reg.mode == lpmc_pkg::MODE_ACTIVE && HALT_EXEC_IN && !STOP_EXEC_IN |=> ##1
    (!POWER_OUT.cpu_run && POWER_OUT.pc_hold))
    else $error("halt did not stall cpu");

  a_halt_clocks_run: assert property (
    state_reg.mode == lpmc_pkg::MODE_HALT |=> POWER_OUT.sys_clk_en && POWER_OUT.osc_run && POWER_OUT.periph_run)
    else $error("clocks stopped in halt");

  a_halt_exit_resume: assert property (
    state_reg.mode == lpmc_pkg::MODE_HALT && (IRQ_IN || WDT_TIMEOUT_IN) |=> POWER_OUT.resume ##1 POWER_OUT.cpu_run)
    else $error("halt exit missed");

  a_stop_only_recovery: assert property (
    stop_now && !STOP_RECOVERY_IN |=> state_reg.mode == lpmc_pkg::MODE_STOP)
    else $error("stop left without recovery");

  a_stop_analog_off: assert property (
    stop_now && !analog_eff[lpmc_pkg::BIT_FREC] |=>
    !POWER_OUT.amp0 && !POWER_OUT.amp1 && !POWER_OUT.cmp0 && !POWER_OUT.cmp1)
    else $error("analog block on in stop");

  a_absent_ignored: assert property (
    !PERIPH_PRESENT[lpmc_pkg::BIT_AMP1] |-> !POWER_OUT.amp1)
    else $error("absent amplifier enabled");

  a_wake_delay_count: assert property (
    s_demand_trigger |-> s_wake_then_start)
    else $error("wake delay wrong");

  a_no_wake_delay: assert property (
    state_reg.conv == lpmc_pkg::CONV_IDLE && ADC_TRIGGER_IN && !stop_now && cont_policy |=> POWER_OUT.conv_start)
    else $error("continuous policy delayed start");

  a_policy_write: assert property (
    state_reg.aw_got && state_reg.w_got && !state_reg.rsp.bvalid && state_reg.wlane &&
    state_reg.aw_idx == lpmc_pkg::IDX_POLICY |=>
    state_reg.policy == ($past(state_reg.wbyte) & lpmc_pkg::POLICY_MASK) && AXI_RSP_OUT.bvalid)
    else $error("policy write lost");

  a_lvd_in_stop: assert property (
    stop_now && analog_eff[lpmc_pkg::BIT_LVD] |=> POWER_OUT.low_voltage_detect_enable)
    else $error("lvd dropped in stop");

endmodule // lpmc_low_power_mode_control
`default_nettype wire

// file: lpmc_pkg.sv
`default_nettype none
package lpmc_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned T_WAKE_ADC_NS = 1000;
  localparam int unsigned WAKE_CYCLES   = (T_WAKE_ADC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WAKE_W        = 8;
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_CYCLES - 1);
  localparam logic [WAKE_W-1:0] WAKE_ZERO = 8'h00;

  // register indices; byte address is four times the index
  localparam int          ADDR_W      = 14;
  localparam int          IDX_W       = 12;
  localparam logic [IDX_W-1:0] IDX_ANALOG = 12'hf80;
  localparam logic [IDX_W-1:0] IDX_POLICY = 12'hf81;
  localparam logic [IDX_W-1:0] IDX_STATUS = 12'hf82;

  // analog_power_enable fields
  localparam int BIT_AMP1 = 7;
  localparam int BIT_AMP0 = 6;
  localparam int BIT_LVD  = 4;
  localparam int BIT_FREC = 2;
  localparam int BIT_CMP0 = 1;
  localparam int BIT_CMP1 = 0;
  localparam logic [7:0] ANALOG_RESET = 8'h10;
  localparam logic [7:0] ANALOG_MASK  = 8'hd7;
  localparam logic [7:0] POLICY_RESET = 8'h00;
  localparam logic [7:0] POLICY_MASK  = 8'h0c;
  localparam int POLICY_LO = 2;

  // converter power policy codes
  localparam logic [1:0] ADC_ON_DEMAND = 2'h0;
  localparam logic [1:0] ADC_REF_HOLD  = 2'h1;
  localparam logic [1:0] ADC_CONT      = 2'h2;
  localparam logic [1:0] ADC_CONT_ALT  = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {MODE_ACTIVE = 3'h1, MODE_HALT = 3'h2, MODE_STOP = 3'h4} lpmc_mode_type;
  typedef enum logic [2:0] {CONV_IDLE = 3'h1, CONV_WAKE = 3'h2, CONV_BUSY = 3'h4} lpmc_conv_type;

  typedef struct packed {
    logic               awvalid;
    logic [ADDR_W-1:0]  awaddr;
    logic               wvalid;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bready;
    logic               arvalid;
    logic [ADDR_W-1:0]  araddr;
    logic               rready;
  } lpmc_axi_req_type;

  typedef struct packed {
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } lpmc_axi_rsp_type;

  typedef struct packed {
    logic cpu_run;
    logic pc_hold;
    logic sys_clk_en;
    logic osc_run;
    logic wdt_run;
    logic periph_run;
    logic amp0;
    logic amp1;
    logic cmp0;
    logic cmp1;
    logic low_voltage_detect_enable;
    logic frec;
    logic adc_pwr;
    logic ref_pwr;
    logic conv_start;
    logic resume;
    logic reset_exit;
  } lpmc_power_type;
endpackage
`default_nettype wire

// file: test_low_power_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_low_power_mode_control;
  // amplifier one left unfitted so that an absent enable gets exercised
  localparam logic [7:0]  PRESENT = 8'h57;
  localparam logic [11:0] ANA     = lpmc_pkg::IDX_ANALOG;
  localparam logic [11:0] POL     = lpmc_pkg::IDX_POLICY;
  logic                       clk;
  logic                       rst;
  logic                       ext_n;
  logic                       wdt_en;
  logic                       done;
  logic                       refsel;
  logic [5:0]                 ev;
  lpmc_pkg::lpmc_axi_req_type req;
  lpmc_pkg::lpmc_axi_rsp_type rsp;
  lpmc_pkg::lpmc_power_type   pwr;
  int                         n_mismatch;
  int                         tests_run;
  int                         seed;
  int                         n;
  logic [31:0]                rd;
  logic [31:0]                v;
  logic [31:0]                keep;
  logic [1:0]                 resp;

  // event bits: 0 halt, 1 stop, 2 recovery, 3 irq, 4 watchdog, 5 trigger
  lpmc_low_power_mode_control #(.PERIPH_PRESENT(PRESENT)) lpmc_low_power_mode_control_i (
    .CLK_SYS_IN          (clk),
    .RST_IN              (rst),
    .AXI_REQ_IN          (req),
    .AXI_RSP_OUT         (rsp),
    .HALT_EXEC_IN        (ev[0]),
    .STOP_EXEC_IN        (ev[1]),
    .STOP_RECOVERY_IN    (ev[2]),
    .IRQ_IN              (ev[3]),
    .WDT_TIMEOUT_IN      (ev[4]),
    .WDT_ENABLE_IN       (wdt_en),
    .EXT_RESET_N_IN      (ext_n),
    .ADC_TRIGGER_IN      (ev[5]),
    .ADC_DONE_IN         (done),
    .REF_BUF_SELECTED_IN (refsel),
    .POWER_OUT           (pwr)
  );

  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // enable levels in the order amp0, amp1, cmp0, cmp1, lvd, frec
  function automatic logic [31:0] exp_pwr(input logic [7:0] x);
    logic [7:0] p;
    p = x & PRESENT;
    return {26'h0, p[6], p[7], p[1], p[0], p[4], p[2]};
  endfunction

  // ready is looked at just after an edge, so it is what the next edge samples
  task axi_wr(input logic [11:0] idx, input logic [31:0] d);
    logic aw, w, ta, tw, tb, fin;
    int t;
    @(posedge clk);
    aw = 1'b1; w = 1'b1; fin = 1'b0; t = 0;
    req.awvalid <= 1'b1; req.awaddr <= {idx, 2'b00}; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
    while (!fin && t < 200) begin
      #1;
      ta = aw && rsp.awready; tw = w && rsp.wready; tb = !aw && !w && rsp.bvalid;
      if (tb) resp = rsp.bresp;
      @(posedge clk);
      if (ta) begin aw = 1'b0; req.awvalid <= 1'b0; end
      if (tw) begin w = 1'b0; req.wvalid <= 1'b0; end
      if (tb) begin fin = 1'b1; req.bready <= 1'b0; end
      t++;
    end
    if (!fin) n_mismatch++;
  endtask

  task axi_rd(input logic [11:0] idx);
    logic ar, ta, tb, fin;
    int t;
    @(posedge clk);
    ar = 1'b1; fin = 1'b0; t = 0;
    req.arvalid <= 1'b1; req.araddr <= {idx, 2'b00}; req.rready <= 1'b1;
    while (!fin && t < 200) begin
      #1;
      ta = ar && rsp.arready; tb = !ar && rsp.rvalid;
      if (tb) begin rd = rsp.rdata; resp = rsp.rresp; end
      @(posedge clk);
      if (ta) begin ar = 1'b0; req.arvalid <= 1'b0; end
      if (tb) begin fin = 1'b1; req.rready <= 1'b0; end
      t++;
    end
    if (!fin) n_mismatch++;
  endtask

  task pulse(input logic [5:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 6'h00;
  endtask

  // resume is a single-cycle pulse, so look before the next edge too
  task wait_resume;
    n = 0;
    #1;
    while (!pwr.resume && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // bound reckoned from a few hundred cycles of traffic
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    seed = 32'hf453; n_mismatch = 0; tests_run = 0;
    rst = 1'b1; ev = 6'h00; ext_n = 1'b1; wdt_en = 1'b0; done = 1'b0; refsel = 1'b1; req = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axi_rd(ANA); chk(rd, 32'h10, "analog reset");
    axi_rd(POL); chk(rd, 32'h00, "policy reset");
    // status word: converter idle, mode active
    axi_rd(12'hf82); chk(rd, 32'h09, "status after reset");
    #1;
    chk({26'h0, pwr.amp0, pwr.amp1, pwr.cmp0, pwr.cmp1, pwr.low_voltage_detect_enable, pwr.frec}, exp_pwr(8'h10), "reset levels");
    // random enables, first all ones to hit the absent amplifier
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 32'hffffffff : $random(seed);
      axi_wr(ANA, v); chk(resp, lpmc_pkg::RESP_OKAY, "write resp");
      repeat (2) @(posedge clk);
      #1;
      chk({26'h0, pwr.amp0, pwr.amp1, pwr.cmp0, pwr.cmp1, pwr.low_voltage_detect_enable, pwr.frec}, exp_pwr(v[7:0]), "enables");
      axi_rd(ANA); chk(rd & 32'h57, v & 32'h57, "readback");
    end
    keep = rd;
    axi_wr(12'h001, 32'h5a); chk(resp, lpmc_pkg::RESP_SLVERR, "unmapped write");
    axi_rd(12'h001); chk(resp, lpmc_pkg::RESP_SLVERR, "unmapped read resp");
    chk(rd, 32'h0, "unmapped read data");
    // halt, then leave by interrupt, watchdog and external pin
    for (int s = 0; s < 3; s++) begin
      @(posedge clk) wdt_en <= 1'($random(seed));
      pulse(6'h01);
      @(posedge clk);
      #1;
      chk({pwr.cpu_run, pwr.pc_hold, pwr.sys_clk_en, pwr.osc_run, pwr.periph_run, pwr.wdt_run},
          {5'b01111, wdt_en}, "halt levels");
      if (s == 2) begin
        @(posedge clk) ext_n <= 1'b0;
        repeat (2) @(posedge clk);
        ext_n <= 1'b1;
      end else pulse((s == 0) ? 6'h08 : 6'h10);
      wait_resume;
      chk({pwr.resume, pwr.reset_exit}, {1'b1, s == 2}, "halt exit");
      @(posedge clk);
      #1;
      chk({pwr.cpu_run, pwr.pc_hold}, 2'b10, "running again");
    end
    axi_rd(ANA); chk(rd, keep, "kept over pin reset");
    // stop ignores interrupt and watchdog, only recovery ends it
    pulse(6'h02);
    pulse(6'h18);
    repeat (3) @(posedge clk);
    #1;
    chk(pwr.cpu_run, 1'b0, "still stopped");
    pulse(6'h04);
    wait_resume; chk(pwr.resume, 1'b1, "stop recovery");
    // every converter policy, reserved bits kept at zero; unneeded analog blocks off
    axi_wr(ANA, 32'h10);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk) refsel <= 1'($random(seed));
      axi_wr(POL, c << 2);
      repeat (2) @(posedge clk);
      #1;
      chk({pwr.adc_pwr, pwr.ref_pwr}, {c[1], (c != 0) && refsel}, "idle power");
      @(posedge clk) ev <= 6'h20;
      n = 0;
      do begin
        @(posedge clk) ev <= 6'h00;
        n++;
        #1;
      end while (!pwr.conv_start && n < 300);
      chk(n, (c < 2) ? lpmc_pkg::WAKE_CYCLES + 1 : 1, "start delay");
      chk(pwr.adc_pwr, 1'b1, "powered at start");
      @(posedge clk) done <= 1'b1;
      @(posedge clk) done <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(pwr.adc_pwr, c[1], "power after done");
    end
    // power-on reset in mid-run restores defaults
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axi_rd(ANA); chk(rd, 32'h10, "analog after por");
    axi_rd(POL); chk(rd, 32'h00, "policy after por");
    tally_and_finish;
  end
endmodule // test_low_power_mode_control
`default_nettype wire
